// ---- rtl/eeprom_pio_defs.svh ----
/*
 * Constants of the serial EEPROM and I/O line slave: offsets, fields, resets, timing.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef EEPROM_PIO_DEFS_SVH
`define EEPROM_PIO_DEFS_SVH

// ****************************************
// Slave addresses (7-bit)
// ****************************************
`define ADDR_LOWER      7'h50
`define ADDR_UPPER      7'h51

// ****************************************
// Lower half offsets and upper half status offset
// ****************************************
`define RSV_FIRST       8'h78
`define RSV_LAST        8'h79
`define REG_CONTROL     8'h7A
`define REG_AUX         8'h7B
`define IO_FIRST        8'h7C
`define IO_LAST         8'h7F
`define STATUS_OFS      8'h6E

// ****************************************
// Control byte fields and values
// ****************************************
`define CTL_SINGLE_BIT  7
`define CTL_MGMT_BIT    6
`define CTL_BUSY_BIT    5
`define CTL_STATUS_BIT  4
`define CTL_RESET       8'h00
`define RESERVED_READ   8'hFF
`define AUX_READ        8'h00

// ****************************************
// Timing and sizes
// ****************************************
`define CLK_MHZ         100
`define PROG_TIME_US    10000
`define PROG_CYCLES     (`PROG_TIME_US * `CLK_MHZ)
`define PROG_CNT_W      20
`define FIFO_DEPTH      8
`define IO_LINES        4

`endif

// ---- rtl/eeprom_pio_pkg.sv ----
/*
 * Types of the serial EEPROM and I/O line slave.
 * Assumes the defs header is on the include path.
 */
`include "eeprom_pio_defs.svh"

package eeprom_pio_pkg;

    // ****************************************
    // Link state machine
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_SACK = 3'b010,
        ST_RX   = 3'b011,
        ST_TX   = 3'b100,
        ST_MACK = 3'b101
    } link_state_e;

    // ****************************************
    // One pending programming word
    // ****************************************
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] data;
    } prog_word_s;

    // ****************************************
    // Whole state of the slave
    // ****************************************
    typedef struct packed {
        link_state_e                    st;
        logic [1:0]                     scl_s;
        logic [1:0]                     sda_s;
        logic                           scl_d;
        logic                           sda_d;
        logic [1:0]                     mrst_s;
        logic [`IO_LINES-1:0]           io_s1;
        logic [`IO_LINES-1:0]           io_s2;
        logic [3:0]                     cnt;
        logic [7:0]                     shift;
        logic                           rw;
        logic                           upper;
        logic                           first;
        logic [8:0]                     ptr;
        logic                           io_direct;
        logic                           ack;
        logic                           sda_drive;
        logic [7:0]                     ctrl;
        logic [`IO_LINES-1:0]           io_out;
        logic [7:0]                     io_samp;
        logic [7:0]                     io_prev;
        logic                           pend;
        logic                           busy;
        logic [`PROG_CNT_W-1:0]         prog_cnt;
        logic [511:0][7:0]              mem;
    } slave_state_s;

endpackage

// ---- rtl/byte_fifo.sv ----
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/10ps
`include "eeprom_pio_defs.svh"

module byte_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rstn,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } fifo_state_s;

    fifo_state_s s_reg;
    fifo_state_s s_next;
    logic        full;
    logic        empty;

    // Extra pointer bit tells full from empty
    assign empty     = (s_reg.wp == s_reg.rp);
    assign full      = (s_reg.wp[AW] != s_reg.rp[AW]) && (s_reg.wp[AW-1:0] == s_reg.rp[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = s_reg.mem[s_reg.rp[AW-1:0]];

    always_comb begin
        s_next = s_reg;
        if (in_valid && !full) begin
            s_next.mem[s_reg.wp[AW-1:0]] = in_data;
            s_next.wp = s_reg.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            s_next.rp = s_reg.rp + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule // byte_fifo

// ---- rtl/eeprom_pio_serial_slave.sv ----
/*
 * Two-wire slave front end of a 512-byte EEPROM with four I/O lines.
 * Assumes the serial clock and data come from pins and are sampled by core_clk,
 * which must run well above the serial clock rate.
 */
`timescale 1ns/10ps
`include "eeprom_pio_defs.svh"

// What this block does
// - Early revision samples I/O at last bit and reports it one byte later.
// - Plain two-wire mode after reset; control write with mode bit clear keeps it.
// - Control write with mode bit set selects management mode until reset or a control write with it clear.
// - Plain mode refuses the write address while programming runs.
// - Management mode lets master read control byte; busy bit clears when done.
// - Reads not started in the I/O range supply consecutive bytes across the whole memory.
// - Status enable bit maps status byte at upper half offset 6Eh.
// - Control bit 7 picks I/O address mode; low nibble sets directions.
// - Multi mode: one line per address from 7Ch; single mode: one byte.
// - Clock is input only; data driven open-drain.
// - Direct I/O reads in multi mode wrap 7Fh back to 7Ch.
module eeprom_pio_serial_slave #(
    parameter int unsigned PROG_CYCLES    = `PROG_CYCLES,
    parameter bit          EARLY_REVISION = 1'b1
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rstn,
    input  wire logic                 manual_reset_input_n,
    // Serial bus
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output logic                      sda_out,
    output logic                      sda_oe,
    // I/O lines
    input  wire logic [`IO_LINES-1:0] io_line_in,
    output logic      [`IO_LINES-1:0] io_line_out,
    output logic      [`IO_LINES-1:0] io_line_oe,
    // Module status byte
    input  wire logic [7:0]           module_status_in
);
    eeprom_pio_pkg::slave_state_s s_reg;
    eeprom_pio_pkg::slave_state_s s_next;
    eeprom_pio_pkg::prog_word_s   push_word;
    eeprom_pio_pkg::prog_word_s   pop_word;
    logic                         push;
    logic                         push_ready;
    logic                         pop_valid;
    logic                         scl_rise;
    logic                         scl_fall;
    logic                         start;
    logic                         stop;
    logic                         load;
    logic                         addr_ok;
    logic                         lower;
    logic [7:0]                   off;
    logic                         in_io;
    logic [7:0]                   io_byte;
    logic [7:0]                   rd_byte;
    logic [8:0]                   ptr_adv;

    // ****************************************
    // Pin edges and conditions
    // ****************************************
    assign scl_rise = s_reg.scl_s[1] && !s_reg.scl_d;
    assign scl_fall = !s_reg.scl_s[1] && s_reg.scl_d;
    assign start    = s_reg.scl_s[1] && s_reg.scl_d && s_reg.sda_d && !s_reg.sda_s[1];
    assign stop     = s_reg.scl_s[1] && s_reg.scl_d && !s_reg.sda_d && s_reg.sda_s[1];
    assign addr_ok  = (s_reg.shift[7:1] == `ADDR_LOWER) || (s_reg.shift[7:1] == `ADDR_UPPER);
    assign lower    = !s_reg.ptr[8];
    assign off      = s_reg.ptr[7:0];
    assign in_io    = lower && (off >= `IO_FIRST) && (off <= `IO_LAST);
    assign load     = scl_fall && s_reg.ack && s_reg.rw &&
                      ((s_reg.st == eeprom_pio_pkg::ST_SACK) ||
                       (s_reg.st == eeprom_pio_pkg::ST_MACK));

    // Present I/O sample in the layout of the current address mode
    assign io_byte = s_reg.ctrl[`CTL_SINGLE_BIT] ? {4'h0, s_reg.io_s2} :
                     {7'h00, s_reg.io_s2[s_reg.ptr[1:0]]};

    // ****************************************
    // Read data and pointer advance
    // ****************************************
    always_comb begin
        rd_byte = s_reg.mem[s_reg.ptr];
        if (lower && (off >= `RSV_FIRST) && (off <= `RSV_LAST)) begin
            rd_byte = `RESERVED_READ;
        end else if (lower && (off == `REG_CONTROL)) begin
            rd_byte = s_reg.ctrl;
            rd_byte[`CTL_BUSY_BIT] = s_reg.busy;
        end else if (lower && (off == `REG_AUX)) begin
            rd_byte = `AUX_READ;
        end else if (in_io) begin
            // Early parts lag one byte; the first byte is stale
            rd_byte = EARLY_REVISION ? s_reg.io_prev : s_reg.io_samp;
        end else if (!lower && (off == `STATUS_OFS) && s_reg.ctrl[`CTL_STATUS_BIT]) begin
            rd_byte = module_status_in;
        end
        if (s_reg.io_direct && s_reg.ctrl[`CTL_SINGLE_BIT]) begin
            ptr_adv = s_reg.ptr;
        end else if (s_reg.io_direct) begin
            ptr_adv = {1'b0, off[7:2], 2'(off[1:0] + 2'd1)};
        end else begin
            ptr_adv = 9'(s_reg.ptr + 9'd1);
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_next           = s_reg;
        push             = 1'b0;
        push_word        = '0;
        s_next.scl_s     = {s_reg.scl_s[0], scl_in};
        s_next.sda_s     = {s_reg.sda_s[0], sda_in};
        s_next.scl_d     = s_reg.scl_s[1];
        s_next.sda_d     = s_reg.sda_s[1];
        s_next.mrst_s    = {s_reg.mrst_s[0], manual_reset_input_n};
        s_next.io_s1     = io_line_in;
        s_next.io_s2     = s_reg.io_s1;
        // Programming drains queued words; link memory writes are refused meanwhile
        if (s_reg.busy) begin
            if (pop_valid) begin
                s_next.mem[pop_word.addr] = pop_word.data;
            end
            s_next.prog_cnt = `PROG_CNT_W'(s_reg.prog_cnt - 1'b1);
            if (s_reg.prog_cnt <= `PROG_CNT_W'(1)) begin
                s_next.busy = 1'b0;
            end
        end
        if (scl_fall && (s_reg.st != eeprom_pio_pkg::ST_IDLE) &&
            (s_reg.st != eeprom_pio_pkg::ST_SACK) && (s_reg.st != eeprom_pio_pkg::ST_MACK) &&
            (s_reg.cnt == (EARLY_REVISION ? 4'd8 : 4'd7))) begin
            s_next.io_samp = io_byte;
        end
        if (start) begin
            s_next.st        = eeprom_pio_pkg::ST_ADDR;
            s_next.cnt       = 4'h0;
            s_next.sda_drive = 1'b0;
        end else if (stop) begin
            s_next.st        = eeprom_pio_pkg::ST_IDLE;
            s_next.sda_drive = 1'b0;
            if (s_reg.pend && !s_reg.busy) begin
                s_next.pend     = 1'b0;
                s_next.busy     = 1'b1;
                s_next.prog_cnt = `PROG_CNT_W'(PROG_CYCLES);
            end
        end else begin
            case (s_reg.st)
                eeprom_pio_pkg::ST_ADDR, eeprom_pio_pkg::ST_RX: begin
                    if (scl_rise) begin
                        s_next.shift = {s_reg.shift[6:0], s_reg.sda_s[1]};
                        s_next.cnt   = 4'(s_reg.cnt + 4'd1);
                    end
                    if (scl_fall && (s_reg.cnt == 4'd8)) begin
                        s_next.st  = eeprom_pio_pkg::ST_SACK;
                        s_next.ack = 1'b1;
                        if (s_reg.st == eeprom_pio_pkg::ST_ADDR) begin
                            s_next.rw        = s_reg.shift[0];
                            s_next.upper     = s_reg.shift[1];
                            s_next.first     = !s_reg.shift[0];
                            s_next.io_direct = s_reg.shift[0] && in_io;
                            s_next.ack       = addr_ok && (!s_reg.busy ||
                                               s_reg.ctrl[`CTL_MGMT_BIT]);
                        end else if (s_reg.first) begin
                            s_next.first = 1'b0;
                            s_next.ptr   = {s_reg.upper, s_reg.shift};
                        end else begin
                            if (lower && (off == `REG_CONTROL)) begin
                                s_next.ctrl = s_reg.shift;
                                s_next.ctrl[`CTL_BUSY_BIT] = 1'b0;
                            end else if (in_io && s_reg.ctrl[`CTL_SINGLE_BIT]) begin
                                s_next.io_out = s_reg.shift[3:0];
                            end else if (in_io) begin
                                s_next.io_out[off[1:0]] = s_reg.shift[0];
                            end else if (push_ready && !s_reg.busy) begin
                                push           = 1'b1;
                                push_word.addr = s_reg.ptr;
                                push_word.data = s_reg.shift;
                                s_next.pend    = 1'b1;
                            end else begin
                                s_next.ack = 1'b0;
                            end
                            if (s_next.ack) begin
                                s_next.ptr = {s_reg.ptr[8], 8'(off + 8'd1)};
                            end
                        end
                        s_next.sda_drive = s_next.ack;
                    end
                end
                eeprom_pio_pkg::ST_SACK, eeprom_pio_pkg::ST_MACK: begin
                    if (scl_rise && (s_reg.st == eeprom_pio_pkg::ST_MACK)) begin
                        s_next.ack = !s_reg.sda_s[1];
                    end
                    if (scl_fall) begin
                        s_next.sda_drive = 1'b0;
                        s_next.cnt       = 4'h0;
                        if (!s_reg.ack) begin
                            s_next.st = eeprom_pio_pkg::ST_IDLE;
                        end else if (s_reg.rw) begin
                            s_next.st        = eeprom_pio_pkg::ST_TX;
                            s_next.shift     = rd_byte;
                            s_next.sda_drive = !rd_byte[7];
                            s_next.ptr       = ptr_adv;
                            s_next.io_prev   = s_reg.io_samp;
                        end else begin
                            s_next.st = eeprom_pio_pkg::ST_RX;
                        end
                    end
                end
                eeprom_pio_pkg::ST_TX: begin
                    if (scl_rise) begin
                        s_next.cnt = 4'(s_reg.cnt + 4'd1);
                    end
                    if (scl_fall && (s_reg.cnt == 4'd8)) begin
                        s_next.sda_drive = 1'b0;
                        s_next.st        = eeprom_pio_pkg::ST_MACK;
                    end else if (scl_fall) begin
                        s_next.shift     = {s_reg.shift[6:0], 1'b0};
                        s_next.sda_drive = !s_reg.shift[6];
                    end
                end
                default: begin
                    s_next.st = eeprom_pio_pkg::ST_IDLE;
                end
            endcase
        end
        // Manual reset returns link and modes to power-on; memory survives
        if (!s_reg.mrst_s[1]) begin
            s_next.st        = eeprom_pio_pkg::ST_IDLE;
            s_next.ctrl      = `CTL_RESET;
            s_next.io_out    = '0;
            s_next.sda_drive = 1'b0;
            s_next.ack       = 1'b0;
            s_next.io_direct = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_reg      <= '0;
            s_reg.ctrl <= `CTL_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // Programming queue
    // ****************************************
    byte_fifo #(
        .WIDTH ($bits(eeprom_pio_pkg::prog_word_s)),
        .DEPTH (`FIFO_DEPTH)
    ) u_prog_fifo (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .in_valid  (push),
        .in_data   (push_word),
        .in_ready  (push_ready),
        .out_valid (pop_valid),
        .out_data  (pop_word),
        .out_ready (s_reg.busy)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign sda_out = 1'b0;
    assign sda_oe  = s_reg.sda_drive;

    genvar gi;
    for (gi = 0; gi < `IO_LINES; gi++) begin : g_io
        assign io_line_out[gi] = s_reg.io_out[gi];
        assign io_line_oe[gi]  = !s_reg.ctrl[gi];
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sda_edge_only_a: assert property (
        $changed(sda_oe) |-> $past(scl_fall) || $past(start) || $past(stop) || !$past(s_reg.mrst_s[1])
    ) else $error("data line changed outside a clock low edge");
    busy_nack_a: assert property (
        ($past(s_reg.st) == eeprom_pio_pkg::ST_ADDR) && (s_reg.st == eeprom_pio_pkg::ST_SACK) &&
        !s_reg.rw && !s_reg.ctrl[`CTL_MGMT_BIT] && $past(s_reg.busy) |-> !s_reg.ack && !sda_oe
    ) else $error("write address acknowledged while busy");
    poll_ack_a: assert property (
        ($past(s_reg.st) == eeprom_pio_pkg::ST_ADDR) && (s_reg.st == eeprom_pio_pkg::ST_SACK) &&
        s_reg.rw && s_reg.ctrl[`CTL_MGMT_BIT] && ($past(s_reg.shift) == {`ADDR_LOWER, 1'b1})
        |-> s_reg.ack
    ) else $error("management read not acknowledged");
    busy_report_a: assert property (
        load && (s_reg.ptr == {1'b0, `REG_CONTROL}) |=> s_reg.shift[`CTL_BUSY_BIT] == $past(s_reg.busy)
    ) else $error("busy bit misreported");
    mode_persist_a: assert property (
        $changed(s_reg.ctrl[`CTL_MGMT_BIT]) |->
            ($past(s_reg.st) == eeprom_pio_pkg::ST_RX) || !$past(s_reg.mrst_s[1])
    ) else $error("bus mode changed without a control write");
    reset_mode_a: assert property (
        !s_reg.mrst_s[1] |=> !s_reg.ctrl[`CTL_MGMT_BIT]
    ) else $error("management mode survived reset");
    seq_read_a: assert property (
        load && !s_reg.io_direct |=> s_reg.ptr == 9'($past(s_reg.ptr) + 9'd1)
    ) else $error("read pointer did not advance");
    io_wrap_a: assert property (
        s_reg.io_direct && s_reg.rw && (s_reg.st == eeprom_pio_pkg::ST_TX) |->
            (s_reg.ptr >= {1'b0, `IO_FIRST}) && (s_reg.ptr <= {1'b0, `IO_LAST})
    ) else $error("direct read left the line range");
    single_write_a: assert property (
        (s_reg.st == eeprom_pio_pkg::ST_RX) && scl_fall && (s_reg.cnt == 4'd8) && !s_reg.first &&
        (s_reg.ptr == {1'b0, `IO_FIRST}) && s_reg.ctrl[`CTL_SINGLE_BIT] && s_reg.mrst_s[1]
        |=> io_line_out == $past(s_reg.shift[3:0])
    ) else $error("single mode write missed the lines");
    late_io_a: assert property (
        load && in_io && EARLY_REVISION |=> s_reg.shift == $past(s_reg.io_prev)
    ) else $error("line sample not reported one byte late");
    status_map_a: assert property (
        load && (s_reg.ptr == {1'b1, `STATUS_OFS}) && s_reg.ctrl[`CTL_STATUS_BIT]
        |=> s_reg.shift == $past(module_status_in)
    ) else $error("status byte not mapped");

    prog_done_c: cover property ($fell(s_reg.busy));
    direct_read_c: cover property (load && s_reg.io_direct);
    mgmt_mode_c: cover property ($rose(s_reg.ctrl[`CTL_MGMT_BIT]));
    fifo_full_c: cover property (!push_ready);
endmodule // eeprom_pio_serial_slave

// ---- tb/i2c_master_model.sv ----
/*
 * Two-wire bus master model: push-pull clock, open-drain data with pull-up.
 * Assumes the slave pulls data low while its enable is high.
 */
`timescale 1ns/10ps
module i2c_master_model (
    // Bus wires
    output logic      scl,
    output wire logic sda,
    // Slave pull-down
    input  wire logic sda_oe
);
    logic sda_low;
    // Pull-up wins once both parties release the line
    assign sda = !(sda_low || sda_oe);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // ****************************************
    // Bus phases, quarter of a 125 ns period
    // ****************************************
    task automatic start();
        #31.25 sda_low = 1'b0;
        #31.25 scl = 1'b1;
        #31.25 sda_low = 1'b1;
        #31.25 scl = 1'b0;
    endtask
    task automatic stop();
        #31.25 sda_low = 1'b1;
        #31.25 scl = 1'b1;
        #31.25 sda_low = 1'b0;
        #31.25;
    endtask
    task automatic xbit(input logic b, output logic r);
        #31.25 sda_low = !b;
        #31.25 scl = 1'b1;
        #31.25 r = sda;
        #31.25 scl = 1'b0;
    endtask
    // Data change only while the clock is low, so no false START or STOP
    task automatic xfer(input logic [7:0] d, input logic mack,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
        xbit(mack, ack);
    endtask
endmodule // i2c_master_model

// ---- tb/eeprom_pio_serial_slave_tb.sv ----
/*
 * Self-checking bench of the EEPROM and I/O line slave.
 * Assumes the master model is compiled first and the defs header is on the path.
 */
`timescale 1ns/10ps
`include "eeprom_pio_defs.svh"
module eeprom_pio_serial_slave_tb;
    logic       core_clk, rstn, manual_reset_input_n, sda_out, sda_oe, k;
    logic [3:0] io_line_in, io_line_out, io_line_oe;
    logic [7:0] module_status_in, q;
    wire        scl, sda;
    int         n_errors, comparisons;
    // Programming shortened so a poll sequence stays short
    eeprom_pio_serial_slave #(.PROG_CYCLES(400)) eeprom_pio_serial_slave_i (
        .core_clk(core_clk), .rstn(rstn), .manual_reset_input_n(manual_reset_input_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .io_line_in(io_line_in), .io_line_out(io_line_out), .io_line_oe(io_line_oe),
        .module_status_in(module_status_in));
    i2c_master_model i2c_master_model_i (.scl(scl), .sda(sda), .sda_oe(sda_oe));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = !core_clk;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic [2:0] ak;
        i2c_master_model_i.start();
        i2c_master_model_i.xfer({`ADDR_LOWER, 1'b0}, 1'b1, q, ak[2]);
        i2c_master_model_i.xfer(ofs, 1'b1, q, ak[1]);
        i2c_master_model_i.xfer(d, 1'b1, q, ak[0]);
        i2c_master_model_i.stop();
        chk({5'h00, ak}, 8'h00);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] ofs, input int n);
        i2c_master_model_i.start();
        i2c_master_model_i.xfer({a, 1'b0}, 1'b1, q, k);
        i2c_master_model_i.xfer(ofs, 1'b1, q, k);
        i2c_master_model_i.start();
        i2c_master_model_i.xfer({a, 1'b1}, 1'b1, q, k);
        i2c_master_model_i.xfer(8'hFF, n == 1, q, k);
        if (n == 2) chk(q, 8'h5A);
        if (n == 2) i2c_master_model_i.xfer(8'hFF, 1'b1, q, k);
        i2c_master_model_i.stop();
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_control();
        chk({4'h0, io_line_oe}, 8'h0F);
        wr(8'h7A, 8'h00);
        rd(`ADDR_LOWER, 8'h7A, 1);
        chk(q, 8'h00);
        wr(8'h7A, 8'h40);
        rd(`ADDR_LOWER, 8'h7A, 1);
        chk(q, 8'h40);
        @(posedge core_clk) manual_reset_input_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        manual_reset_input_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        #2;
        rd(`ADDR_LOWER, 8'h7A, 1);
        chk(q, 8'h00);
    endtask
    task automatic t_lines();
        i2c_master_model_i.start();
        i2c_master_model_i.xfer({`ADDR_LOWER, 1'b0}, 1'b1, q, k);
        i2c_master_model_i.xfer(`IO_FIRST, 1'b1, q, k);
        for (int n = 0; n < 4; n++) i2c_master_model_i.xfer({7'h00, n != 1}, 1'b1, q, k);
        i2c_master_model_i.stop();
        chk({4'h0, io_line_out}, 8'h0D);
        wr(8'h7A, 8'h80);
        wr(`IO_FIRST, 8'h0A);
        chk({4'h0, io_line_out}, 8'h0A);
        wr(8'h7A, 8'h0F);
        chk({4'h0, io_line_oe}, 8'h00);
    endtask
    task automatic t_direct();
        i2c_master_model_i.start();
        i2c_master_model_i.xfer({`ADDR_LOWER, 1'b0}, 1'b1, q, k);
        i2c_master_model_i.xfer(8'h7D, 1'b1, q, k);
        i2c_master_model_i.start();
        i2c_master_model_i.xfer({`ADDR_LOWER, 1'b1}, 1'b1, q, k);
        i2c_master_model_i.xfer(8'hFF, 1'b0, q, k);
        // Lines 1, 2, 3 then back to 0; pins hold 0110
        for (int n = 0; n < 4; n++) begin
            i2c_master_model_i.xfer(8'hFF, n == 3, q, k);
            chk(q, {7'h00, n < 2});
        end
        i2c_master_model_i.stop();
    endtask
    task automatic t_memory();
        logic first;
        i2c_master_model_i.start();
        i2c_master_model_i.xfer({`ADDR_LOWER, 1'b0}, 1'b1, q, k);
        i2c_master_model_i.xfer(8'h10, 1'b1, q, k);
        i2c_master_model_i.xfer(8'h5A, 1'b1, q, k);
        i2c_master_model_i.xfer(8'hA5, 1'b1, q, k);
        i2c_master_model_i.stop();
        i2c_master_model_i.start();
        i2c_master_model_i.xfer({`ADDR_LOWER, 1'b0}, 1'b1, q, first);
        k = first;
        // Address polling with repeated STARTs, bounded
        for (int n = 0; n < 20 && k; n++) begin
            i2c_master_model_i.start();
            i2c_master_model_i.xfer({`ADDR_LOWER, 1'b0}, 1'b1, q, k);
        end
        i2c_master_model_i.stop();
        chk({7'h00, first}, 8'h01);
        chk({7'h00, k}, 8'h00);
        wr(8'h7A, 8'h40);
        wr(8'h20, 8'h3C);
        q = 8'h20;
        for (int n = 0; n < 20 && q[5]; n++) rd(`ADDR_LOWER, 8'h7A, 1);
        rd(`ADDR_LOWER, 8'h7A, 1);
        chk(q, 8'h40);
        rd(`ADDR_LOWER, 8'h10, 2);
        chk(q, 8'hA5);
        wr(8'h7A, 8'h10);
        rd(`ADDR_UPPER, `STATUS_OFS, 1);
        chk(q, 8'hC3);
        chk({7'h00, sda_out}, 8'h00);
    endtask
    initial begin
        rstn = 1'b0;
        manual_reset_input_n = 1'b1;
        io_line_in = 4'h6;
        module_status_in = 8'h00;
        n_errors = 0;
        comparisons = 0;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        module_status_in <= 8'hC3;
        repeat (8) @(posedge core_clk);
        #2;
        t_control();
        t_lines();
        t_direct();
        t_memory();
        print_verdict();
    end
    initial begin
        #300000;
        n_errors++;
        print_verdict();
    end
endmodule // eeprom_pio_serial_slave_tb
